//--- hw/lcdcd_pkg.sv
// Constants and types shared by the LCD driver command decoder
package lcdcd_pkg;
    // System clock and display clock
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned DISP_CLK_HZ    = 1536;
    localparam int unsigned DISP_DIV_CYC   = CLK_HZ / DISP_CLK_HZ;
    // Blink periods in display clock ticks, toggled at half period
    localparam logic [11:0] BLINK_DIV_1    = 12'h300;
    localparam logic [11:0] BLINK_DIV_2    = 12'h600;
    localparam logic [11:0] BLINK_DIV_3    = 12'hC00;
    // Command opcodes and their compare widths
    localparam logic [3:0]  OP_MODE_SET    = 4'hC;
    localparam logic [4:0]  OP_DEV_SEL     = 5'h1C;
    localparam logic [5:0]  OP_BANK_SEL    = 6'h3E;
    localparam logic [4:0]  OP_BLINK_SEL   = 5'h1E;
    // Field positions
    localparam int unsigned BIT_PTR_OP     = 7;
    localparam int unsigned BIT_DISP_EN    = 3;
    localparam int unsigned BIT_BIAS       = 2;
    localparam int unsigned BIT_IN_BANK    = 1;
    localparam int unsigned BIT_OUT_BANK   = 0;
    localparam int unsigned BIT_BLINK_ALT  = 2;
    localparam int unsigned BIT_CONTINUE   = 7;
    localparam int unsigned BIT_TARGET     = 6;
    // Drive modes
    localparam logic [1:0]  MODE_STATIC    = 2'h1;
    localparam logic [1:0]  MODE_MUX2      = 2'h2;
    localparam logic [1:0]  MODE_MUX3      = 2'h3;
    localparam logic [1:0]  MODE_MUX4      = 2'h0;
    // Pointer advance per data byte in each drive mode
    localparam logic [7:0]  STEP_STATIC    = 8'h08;
    localparam logic [7:0]  STEP_MUX2      = 8'h04;
    localparam logic [7:0]  STEP_MUX3      = 8'h03;
    localparam logic [7:0]  STEP_MUX4      = 8'h02;
    localparam logic [7:0]  RAM_DEPTH      = 8'h3C;
    // Reset values
    localparam logic [1:0]  RST_MODE       = MODE_MUX4;
    localparam logic [1:0]  RATE_OFF       = 2'h0;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_CTRL   = 4'h2,
        ST_ONE    = 4'h4,
        ST_STREAM = 4'h8
    } lcdcd_state_t;
endpackage

//--- hw/lcdcd_decoder.sv
// Command and display data decoder of a segment LCD driver
module lcdcd_decoder
    import lcdcd_pkg::*;
#(
    parameter int unsigned DISP_DIV = DISP_DIV_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       rx_start,
    input  wire logic       rx_read,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_stop,
    input  wire logic [2:0] hw_subaddress_pins,
    output logic            display_on,
    output logic            bias_half,
    output logic [1:0]      drive_mode,
    output logic [6:0]      ram_pointer,
    output logic [2:0]      subaddress,
    output logic            input_bank,
    output logic            output_bank,
    output logic            blink_alt,
    output logic [1:0]      blink_rate_field,
    output logic            ram_we,
    output logic [6:0]      ram_addr,
    output logic [7:0]      ram_wdata,
    output logic            ram_wbank,
    output logic [1:0]      ram_wmode
);
    localparam int unsigned DIVW = $clog2(DISP_DIV);

    // A divide by one would leave the counter no width at all
    if (DISP_DIV < 2) begin : g_bad_div
        $error("DISP_DIV must be at least 2");
    end


    typedef struct packed {
        logic [2:0]      sync1;
        logic [2:0]      sync2;
        logic [2:0]      sync3;
        logic [2:0]      pins;
        lcdcd_state_t    state;
        logic            tgt_data;
        logic            ignore;
        logic            disp_en;
        logic            bias_half;
        logic [1:0]      mode;
        logic [6:0]      ptr;
        logic [2:0]      sub;
        logic            in_bank;
        logic            out_bank;
        logic            alt;
        logic [1:0]      rate;
        logic [DIVW-1:0] div_cnt;
        logic [11:0]     blink_cnt;
        logic            phase;
        logic            disp_on;
        logic            out_bank_eff;
        logic            we;
        logic [6:0]      waddr;
        logic [7:0]      wdata;
        logic            wbank;
        logic [1:0]      wmode;
    } lcdcd_reg_t;

    lcdcd_reg_t r_q;
    lcdcd_reg_t r_d;

    logic        low_mux;
    logic        tick;
    logic [11:0] half_period;
    logic [7:0]  step;
    logic [7:0]  next_ptr;
    logic        is_ptr;
    logic        is_mode;
    logic        is_dev;
    logic        is_bank;
    logic        is_blink;
    logic        take;
    logic        sub_match;

    always_comb begin
        r_d = r_q;

        // Pins pass three flops; a change counts once two and three agree
        r_d.sync1 = hw_subaddress_pins;
        r_d.sync2 = r_q.sync1;
        r_d.sync3 = r_q.sync2;
        if (r_q.sync2 == r_q.sync3) begin
            r_d.pins = r_q.sync3;
        end

        // Write strobe lasts one cycle unless a stored byte raises it
        r_d.we = 1'b0;

        low_mux = (r_q.mode == MODE_STATIC) || (r_q.mode == MODE_MUX2);

        unique case (r_q.mode)
            MODE_STATIC: begin
                step = STEP_STATIC;
            end
            MODE_MUX2: begin
                step = STEP_MUX2;
            end
            MODE_MUX3: begin
                step = STEP_MUX3;
            end
            MODE_MUX4: begin
                step = STEP_MUX4;
            end
        endcase
        next_ptr = {1'b0, r_q.ptr} + step;

        // Opcode classes; the pointer load is tested first
        is_ptr   = !rx_byte[BIT_PTR_OP];
        is_mode  = (rx_byte[7:4] == OP_MODE_SET);
        is_dev   = (rx_byte[7:3] == OP_DEV_SEL);
        is_bank  = (rx_byte[7:2] == OP_BANK_SEL);
        is_blink = (rx_byte[7:3] == OP_BLINK_SEL);

        // A byte in the stop cycle is dropped
        take = rx_valid && !r_q.ignore && !rx_stop
            && ((r_q.state == ST_ONE) || (r_q.state == ST_STREAM));

        // Only the device whose pins match the subaddress stores
        sub_match = (r_q.sub == r_q.pins);

        // Control byte framing
        unique case (r_q.state)
            ST_IDLE: begin
                if (rx_start) begin
                    r_d.state  = ST_CTRL;
                    r_d.ignore = rx_read;
                end
            end
            ST_CTRL: begin
                if (rx_valid) begin
                    r_d.tgt_data = rx_byte[BIT_TARGET];
                    if (rx_byte[BIT_CONTINUE]) begin
                        r_d.state = ST_ONE;
                    end else begin
                        r_d.state = ST_STREAM;
                    end
                end
            end
            ST_ONE: begin
                if (rx_valid) begin
                    r_d.state = ST_CTRL;
                end
            end
            ST_STREAM: begin
                // Held until the stop ends the frame
            end
        endcase

        if (rx_stop) begin
            r_d.state = ST_IDLE;
        end

        if (take) begin
            if (r_q.tgt_data) begin
                r_d.we    = sub_match;
                r_d.waddr = r_q.ptr;
                r_d.wdata = rx_byte;
                r_d.wbank = r_q.in_bank & low_mux;
                r_d.wmode = r_q.mode;

                // Counters advance in every device, matched or not
                if (next_ptr >= RAM_DEPTH) begin
                    r_d.ptr = 7'(next_ptr - RAM_DEPTH);
                    r_d.sub = r_q.sub + 3'h1;
                end else begin
                    r_d.ptr = next_ptr[6:0];
                end
            end else if (is_ptr) begin
                r_d.ptr = rx_byte[6:0];
            end else if (is_mode) begin
                r_d.disp_en   = rx_byte[BIT_DISP_EN];
                r_d.bias_half = rx_byte[BIT_BIAS];
                r_d.mode      = rx_byte[1:0];
            end else if (is_dev) begin
                r_d.sub = rx_byte[2:0];
            end else if (is_bank) begin
                // Wide modes have no spare bank to switch to
                if (low_mux) begin
                    r_d.in_bank  = rx_byte[BIT_IN_BANK];
                    r_d.out_bank = rx_byte[BIT_OUT_BANK];
                end
            end else if (is_blink) begin
                r_d.alt  = rx_byte[BIT_BLINK_ALT];
                r_d.rate = rx_byte[1:0];
            end
            // Any other byte falls through untouched
        end

        // Display clock enable from the system clock
        tick = (r_q.div_cnt == DIVW'(DISP_DIV - 1));
        if (tick) begin
            r_d.div_cnt = '0;
        end else begin
            r_d.div_cnt = r_q.div_cnt + DIVW'(1);
        end

        unique case (r_q.rate)
            2'h1: begin
                half_period = BLINK_DIV_1 >> 1;
            end
            2'h2: begin
                half_period = BLINK_DIV_2 >> 1;
            end
            2'h3: begin
                half_period = BLINK_DIV_3 >> 1;
            end
            default: begin
                half_period = 12'h000;
            end
        endcase


        // Blink off holds the phase count and phase at zero
        if (r_q.rate == RATE_OFF) begin
            r_d.blink_cnt = 12'h000;
            r_d.phase     = 1'b0;
        end else if (tick) begin
            if (r_q.blink_cnt >= half_period - 12'h001) begin
                r_d.blink_cnt = 12'h000;
                r_d.phase     = ~r_q.phase;
            end else begin
                r_d.blink_cnt = r_q.blink_cnt + 12'h001;
            end
        end

        // Display outputs from the status registers
        if (r_q.alt && low_mux) begin
            r_d.disp_on      = r_q.disp_en;
            r_d.out_bank_eff = r_q.out_bank ^ (r_q.phase & r_q.disp_en);
        end else begin
            r_d.disp_on      = r_q.disp_en & ~r_q.phase;
            r_d.out_bank_eff = r_q.out_bank & low_mux;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q              <= '0;
            r_q.state        <= ST_IDLE;
            r_q.mode         <= RST_MODE;
            r_q.rate         <= RATE_OFF;
        end else begin
            r_q <= r_d;
        end
    end

    assign display_on       = r_q.disp_on;
    assign bias_half        = r_q.bias_half;
    assign drive_mode       = r_q.mode;
    assign ram_pointer      = r_q.ptr;
    assign subaddress       = r_q.sub;
    assign input_bank       = r_q.in_bank;
    assign output_bank      = r_q.out_bank_eff;
    assign blink_alt        = r_q.alt;
    assign blink_rate_field = r_q.rate;
    assign ram_we           = r_q.we;
    assign ram_addr         = r_q.waddr;
    assign ram_wdata        = r_q.wdata;
    assign ram_wbank        = r_q.wbank;
    assign ram_wmode        = r_q.wmode;
endmodule // lcdcd_decoder

//--- test/lcdcd_checker.sv
// Port-level assertions for the LCD driver command decoder
module lcdcd_checker
    import lcdcd_pkg::*;
#(
    parameter int unsigned DISP_DIV = DISP_DIV_CYC
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic       display_on,
    input wire logic       bias_half,
    input wire logic [1:0] drive_mode,
    input wire logic [6:0] ram_pointer,
    input wire logic [2:0] subaddress,
    input wire logic       output_bank,
    input wire logic       blink_alt,
    input wire logic [1:0] blink_rate_field,
    input wire logic       ram_we,
    input wire logic [6:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic       ram_wbank,
    input wire logic [1:0] ram_wmode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] byte_q;
    always_ff @(posedge clk) byte_q <= rx_byte;
    function automatic logic [6:0] next_ptr(logic [6:0] a, logic [1:0] m);
        logic [7:0] s;
        s = {1'b0, a} + (m == MODE_STATIC ? STEP_STATIC :
            m == MODE_MUX2 ? STEP_MUX2 : m == MODE_MUX3 ? STEP_MUX3 : STEP_MUX4);
        return (s >= RAM_DEPTH) ? 7'(s - RAM_DEPTH) : s[6:0];
    endfunction
    // Blink off, so only an enable can light the display
    sequence s_plain_rise;
        blink_rate_field == RATE_OFF && $past(blink_rate_field, 3) == RATE_OFF
            ##0 $rose(display_on);
    endsequence
    reset_vals_a:
        assert property ($rose(reset_n) |-> !display_on && !bias_half
            && drive_mode == RST_MODE && ram_pointer == 7'h00 && !ram_we
            && subaddress == 3'h0 && !output_bank && !blink_alt
            && blink_rate_field == RATE_OFF) else $error("bad reset state");
    ptr_step_a:
        assert property (ram_we |-> ram_pointer == next_ptr(ram_addr, ram_wmode))
        else $error("pointer step wrong");
    ram_data_a:
        assert property (ram_we |-> $past(rx_valid) && ram_wdata == byte_q)
        else $error("written byte wrong");
    wbank_wide_a:
        assert property (ram_we && ram_wmode[1] == ram_wmode[0] |-> !ram_wbank)
        else $error("bank used in wide mux");
    obank_wide_a:
        assert property (drive_mode[1] == drive_mode[0]
            && drive_mode == $past(drive_mode)
            && drive_mode == $past(drive_mode, 2)
            |-> !output_bank) else $error("output bank set in wide mux");
    mode_cause_a:
        assert property ($changed(drive_mode) |-> $past(rx_valid)
            && byte_q[7:4] == OP_MODE_SET && drive_mode == byte_q[1:0])
        else $error("drive mode changed without command");
    bias_cause_a:
        assert property ($changed(bias_half) |-> $past(rx_valid)
            && byte_q[7:4] == OP_MODE_SET && bias_half == byte_q[BIT_BIAS])
        else $error("bias changed without command");
    blink_cause_a:
        assert property ($changed(blink_rate_field) |-> $past(rx_valid)
            && byte_q[7:3] == OP_BLINK_SEL && blink_rate_field == byte_q[1:0])
        else $error("blink rate changed without command");
    sub_cause_a:
        assert property ($changed(subaddress) |-> $past(rx_valid))
        else $error("subaddress moved without a byte");
    disp_rise_a:
        assert property (s_plain_rise |-> $past(rx_valid, 2))
        else $error("display lit without command");
endmodule // lcdcd_checker

bind lcdcd_decoder lcdcd_checker #(.DISP_DIV(DISP_DIV)) u_chk (.*);

//--- test/lcdcd_master_model.sv
// Stand-in for the bus front end that hands bytes to the decoder
module lcdcd_master_model (
    input  wire logic  clk,
    output logic       rx_start,
    output logic       rx_read,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    output logic       rx_stop
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rx_start, rx_read, rx_valid, rx_byte, rx_stop} <= 12'h000;
    task automatic open_frame(input logic rd);
        @(posedge clk);
        rx_start <= 1'b1;
        rx_read  <= rd;
        @(posedge clk);
        rx_start <= 1'b0;
    endtask
    task automatic put(input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        @(posedge clk);
    endtask
    // Released byte lines show the inverse, not a stale copy
    task automatic close_frame();
        rx_valid <= 1'b0;
        rx_byte  <= ~rx_byte;
        rx_stop  <= 1'b1;
        @(posedge clk);
        rx_stop  <= 1'b0;
    endtask
endmodule // lcdcd_master_model

//--- test/tb_top.sv
// Self-checking bench for the LCD driver command decoder
module tb_top
    import lcdcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL_CMD  = 8'h80;
    localparam logic [7:0] CTL_DATA = 8'h40;
    logic       clk, reset_n, rx_start, rx_read, rx_valid, rx_stop;
    logic       display_on, bias_half, input_bank, output_bank;
    logic       blink_alt, ram_we, ram_wbank;
    logic [1:0] drive_mode, blink_rate_field, ram_wmode;
    logic [2:0] pins, subaddress;
    logic [6:0] ram_pointer, ram_addr;
    logic [7:0] rx_byte, ram_wdata;
    int         n_fail = 0, comparisons = 0, cyc = 0, n;
    // Short display tick keeps blink periods simulable
    lcdcd_decoder #(.DISP_DIV(4)) dut (.hw_subaddress_pins(pins), .*);
    lcdcd_master_model m (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b, input logic rd = 1'b0);
        m.open_frame(rd);
        m.put(CTL_CMD);
        m.put(b);
        m.close_frame();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Cycles until the visible display state next changes
    task automatic span();
        logic [1:0] v;
        v = {display_on, output_bank};
        for (n = 0; n < 8000 && {display_on, output_bank} === v; n++) #8;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        reset_n = 1'b0;
        pins = 3'h0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 chk("mode", drive_mode, RST_MODE);
        chk("rate", blink_rate_field, RATE_OFF);
        for (int i = 0; i < 4; i++) begin
            cmd(8'hC8 | 8'(i) | 8'(i % 2 * 4));
            chk("mode", drive_mode, 16'(i));
            chk("bias", bias_half, 16'(i % 2));
            chk("disp", display_on, 1'b1);
        end
        cmd(8'hD9);
        chk("mode", drive_mode, MODE_MUX3);
        cmd(8'hC1, 1'b1);
        chk("disp", display_on, 1'b1);
        cmd(8'hFB);
        chk("obank", output_bank, 1'b0);
        // Alternate mode asked for in mux3 must fall back to blanking
        for (int r = 1; r < 4; r++) begin
            cmd(8'hF0);
            chk("on", display_on, 1'b1);
            cmd(8'hF4 | 8'(r));
            chk("rate", blink_rate_field, 16'(r));
            span();
            span();
            chk("half", 16'(n), 16'(1536 << (r - 1)));
        end
        cmd(8'hF0);
        cmd(8'hC9);
        cmd(8'hFA);
        chk("ibank", input_bank, 1'b1);
        cmd(8'hFB);
        chk("obank", output_bank, 1'b1);
        cmd(8'hF5);
        span();
        span();
        chk("alt", 16'(n), 16'd1536);
        cmd(8'hF0);
        pins <= 3'h5;
        cmd(8'hE5);
        chk("sub", subaddress, 3'h5);
        cmd(8'h3A);
        chk("ptr", ram_pointer, 7'h3A);
        m.open_frame(1'b0);
        m.put(CTL_DATA);
        m.put(8'hA5);
        #1 chk("we", ram_we, 1'b1);
        chk("addr", ram_addr, 7'h3A);
        chk("wdat", ram_wdata, 8'hA5);
        chk("wbank", ram_wbank, 1'b1);
        chk("wmode", ram_wmode, MODE_STATIC);
        chk("sub", subaddress, 3'h6);
        m.put(8'h5A);
        #1 chk("we", ram_we, 1'b0);
        chk("ptr", ram_pointer, 7'h0E);
        m.close_frame();
        wrap_up();
    end
endmodule // tb_top
